// [hdl/cfg_regs_pkg.sv]
// Constants, field layout and states of the chip configuration registers
// What this block does
// - Drive bit 15: 0 partial, 1 full
// - Reset sets size enable, bus watch enable only
// - Drive bit reset value comes from straps
// - Bit 6 picks size pins or DMA acknowledge
// - Bit 5 enables status and debug pins
// - Bit 3 enables bus watch on external cycles
// - Bits 2..0 pick timeout 65536 down to 512
// - Reset defaults register ignores all writes
// - Defaults replaced only by asserted select pin
// - Bits 9..8 map upper address or selects
// - Defaults bit 5 reports strapped drive strength
// - Bits 4..3 report boot port width
// - Mode bit reads one, never overridden
// - Write-once bits lock after first write
// - Debug writes allowed and keep bit open
// - User access ignored and ends in error
// - Straps sampled from data pins at reset
package cfg_regs_pkg;

	// ************************************************
	// Bus and register geometry
	// ************************************************
	localparam int          ADDR_W      = 32;
	localparam int          DATA_W      = 32;
	localparam int          REG_W       = 16;
	localparam int          TSEL_W      = 3;
	localparam int          TMO_W       = 17;
	localparam logic [31:0] CFG_OFFSET  = 32'h0011_0004;
	localparam logic [31:0] DEFS_OFFSET = 32'h0011_0008;
	localparam logic [31:0] RSVD_OFFSET = 32'h0011_000C;

	// ************************************************
	// Field positions
	// ************************************************
	localparam int LOAD_BIT   = 15;
	localparam int XSIZE_BIT  = 6;
	localparam int DBGPIN_BIT = 5;
	localparam int WATCH_BIT  = 3;
	localparam int TSEL_LSB   = 0;
	localparam int CSMAP_LSB  = 8;
	localparam int RDRV_BIT   = 5;
	localparam int BOOT_LSB   = 3;
	localparam int MODE_BIT   = 0;
	localparam int PRIV_BIT   = 0;
	localparam int LANE_LO    = 0;
	localparam int LANE_HI    = 1;

	// ************************************************
	// Reset values and defaults
	// ************************************************
	localparam logic              LOAD_RST    = 1'b0;
	localparam logic              XSIZE_RST   = 1'b1;
	localparam logic              DBGPIN_RST  = 1'b0;
	localparam logic              WATCH_RST   = 1'b1;
	localparam logic [TSEL_W-1:0] TSEL_RST    = 3'h0;
	localparam logic [1:0]        CSMAP_DEF   = 2'h0;
	localparam logic              DRV_DEF     = 1'b0;
	localparam logic [1:0]        BOOT_DEF    = 2'h0;
	localparam logic              MODE_MASTER = 1'b1;
	localparam logic [1:0]        BOOT_16     = 2'h1;
	localparam logic [1:0]        BOOT_8      = 2'h2;
	localparam logic [1:0]        CSMAP_ALL   = 2'h3;

	// ************************************************
	// Timing
	// ************************************************
	localparam logic [TMO_W-1:0] BUS_WATCH_MAX = 17'h10000;

	// ************************************************
	// Strap capture states
	// ************************************************
	typedef enum logic [2:0] {
		ST_SAMPLE = 3'b001,
		ST_LOAD   = 3'b010,
		ST_RUN    = 3'b100
	} strap_state_t;

endpackage

// [hdl/chip_config_regs.sv]
// Chip configuration and reset defaults registers behind an APB slave
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module chip_config_regs
	import cfg_regs_pkg::*;
(
	// Clock and reset
	input  wire logic                              ref_clk,
	input  wire logic                              reset,
	// APB slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [cfg_regs_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [cfg_regs_pkg::DATA_W-1:0]   pwdata,
	input  wire logic [3:0]                        pstrb,
	input  wire logic [2:0]                        pprot,
	output logic      [cfg_regs_pkg::DATA_W-1:0]   prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// Processor state
	input  wire logic                              debug_mode,
	// Reset configuration straps
	input  wire logic                              config_select_pin_n,
	input  wire logic [1:0]                        cs_map_strap,
	input  wire logic                              drive_strap,
	input  wire logic [1:0]                        boot_strap,
	// Pad and pin function controls
	output logic                                   pad_drive_full,
	output logic                                   xfer_size_pin_enable,
	output logic                                   dma_ack_pin_enable,
	output logic                                   debug_status_pin_enable,
	output logic [2:0]                             cs_pin_select,
	// Boot and mode
	output logic                                   boot_port_8bit,
	output logic                                   boot_port_16bit,
	output logic                                   boot_port_32bit,
	output logic                                   chip_master_mode,
	// Bus watch
	output logic                                   bus_watch_enable,
	output logic [cfg_regs_pkg::TMO_W-1:0]         bus_watch_timeout_sel
);

	import cfg_regs_pkg::*;

	// ************************************************
	// Address decode
	// ************************************************
	logic              setup_ph;
	logic              access_ph;
	logic              hit_cfg;
	logic              hit_defs;
	logic              hit_rsvd;
	logic              mapped;
	logic              privileged;
	logic              refused;
	logic              wr_ok;
	logic              cfg_wr;
	logic              cfg_lo_wr;
	logic              cfg_hi_wr;

	assign setup_ph   = psel & ~penable;
	assign access_ph  = psel & penable;
	assign hit_cfg    = (paddr == CFG_OFFSET);
	assign hit_defs   = (paddr == DEFS_OFFSET);
	assign hit_rsvd   = (paddr == RSVD_OFFSET);
	assign mapped     = hit_cfg | hit_defs | hit_rsvd;
	assign privileged = pprot[PRIV_BIT];
	assign refused    = ~mapped | ~privileged;
	assign wr_ok      = access_ph & pwrite & ~refused;
	// Defaults register has no write path at all
	assign cfg_wr     = wr_ok & hit_cfg;
	assign cfg_lo_wr  = cfg_wr & pstrb[LANE_LO];
	assign cfg_hi_wr  = cfg_wr & pstrb[LANE_HI];

	// ************************************************
	// Reset configuration
	// ************************************************
	logic [1:0]        csmap_def;
	logic              drv_def;
	logic [1:0]        boot_def;
	logic              strap_load;

	reset_strap_capture u_strap (
		.ref_clk                 (ref_clk),
		.reset                   (reset),
		.config_select_pin_n     (config_select_pin_n),
		.cs_map_strap            (cs_map_strap),
		.drive_strap             (drive_strap),
		.boot_strap              (boot_strap),
		.chip_select_map_default (csmap_def),
		.pad_drive_default       (drv_def),
		.boot_port_width         (boot_def),
		.strap_load              (strap_load)
	);

	// ************************************************
	// Configuration register fields
	// ************************************************
	logic              load_val;
	logic              load_lock;
	logic              watch_val;
	logic              watch_lock;
	logic [TSEL_W-1:0] tsel_val;
	logic              tsel_lock;
	logic              xsize_r;
	logic              xsize_nxt;
	logic              dbgpin_r;
	logic              dbgpin_nxt;

	// Drive bit starts from the strap, not a constant
	write_once_field #(.W(1), .RST(LOAD_RST)) u_load (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.init_load  (strap_load),
		.init_value (drv_def),
		.wr_en      (cfg_hi_wr),
		.wr_value   (pwdata[LOAD_BIT]),
		.debug_mode (debug_mode),
		.value      (load_val),
		.locked     (load_lock)
	);

	write_once_field #(.W(1), .RST(WATCH_RST)) u_watch (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.init_load  (strap_load),
		.init_value (WATCH_RST),
		.wr_en      (cfg_lo_wr),
		.wr_value   (pwdata[WATCH_BIT]),
		.debug_mode (debug_mode),
		.value      (watch_val),
		.locked     (watch_lock)
	);

	write_once_field #(.W(TSEL_W), .RST(TSEL_RST)) u_tsel (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.init_load  (strap_load),
		.init_value (TSEL_RST),
		.wr_en      (cfg_lo_wr),
		.wr_value   (pwdata[TSEL_LSB+TSEL_W-1:TSEL_LSB]),
		.debug_mode (debug_mode),
		.value      (tsel_val),
		.locked     (tsel_lock)
	);

	assign xsize_nxt  = cfg_lo_wr ? pwdata[XSIZE_BIT]  : xsize_r;
	assign dbgpin_nxt = cfg_lo_wr ? pwdata[DBGPIN_BIT] : dbgpin_r;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			xsize_r  <= XSIZE_RST;
			dbgpin_r <= DBGPIN_RST;
		end else begin
			xsize_r  <= xsize_nxt;
			dbgpin_r <= dbgpin_nxt;
		end
	end

	// ************************************************
	// Register images
	// ************************************************
	logic [REG_W-1:0]  cfg_value;
	logic [REG_W-1:0]  defs_value;
	logic [DATA_W-1:0] rd_value;
	logic [DATA_W-1:0] prdata_r;
	logic [DATA_W-1:0] prdata_nxt;

	// Reserved bits are not stored, so stray ones read back as zero
	assign cfg_value  = {load_val, 8'h00, xsize_r, dbgpin_r, 1'b0,
	                     watch_val, tsel_val};
	assign defs_value = {6'h00, csmap_def, 2'h0, drv_def, boot_def,
	                     2'h0, MODE_MASTER};
	assign rd_value   = (refused | pwrite) ? 32'h0000_0000 :
	                    hit_cfg  ? {16'h0000, cfg_value}  :
	                    hit_defs ? {16'h0000, defs_value} : 32'h0000_0000;
	// Read data is latched in setup so it comes from a flop in access
	assign prdata_nxt = setup_ph ? rd_value : prdata_r;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prdata_r <= 32'h0000_0000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	assign pslverr = access_ph & refused;

	// ************************************************
	// Pin function outputs
	// ************************************************
	assign pad_drive_full          = load_val;
	assign xfer_size_pin_enable    = xsize_r;
	assign dma_ack_pin_enable      = ~xsize_r;
	assign debug_status_pin_enable = dbgpin_r;
	assign bus_watch_enable        = watch_val;
	// Halving per step: 000 is 65536, 111 is 512
	assign bus_watch_timeout_sel   = BUS_WATCH_MAX >> tsel_val;
	assign cs_pin_select           = {csmap_def != 2'h0, csmap_def[1],
	                                  csmap_def == CSMAP_ALL};
	assign boot_port_8bit          = (boot_def == BOOT_8);
	assign boot_port_16bit         = (boot_def == BOOT_16);
	assign boot_port_32bit         = ~boot_port_8bit & ~boot_port_16bit;
	assign chip_master_mode        = defs_value[MODE_BIT];

	// ************************************************
	// Checks
	// ************************************************
	property p_drive_write;
		@(posedge ref_clk) disable iff (reset)
		(cfg_hi_wr && !load_lock && !strap_load)
			|=> pad_drive_full == $past(pwdata[LOAD_BIT]);
	endproperty
	a_drive_write: assert property (p_drive_write)
		else $error("drive strength did not follow first write");

	property p_reset_image;
		@(posedge ref_clk) disable iff (reset)
		$fell(reset) |-> (cfg_value[XSIZE_BIT] && cfg_value[WATCH_BIT]
		                  && cfg_value[14:7] == 8'h00 && !dbgpin_r
		                  && tsel_val == TSEL_RST);
	endproperty
	a_reset_image: assert property (p_reset_image)
		else $error("configuration register reset image wrong");

	property p_drive_from_strap;
		@(posedge ref_clk) disable iff (reset)
		strap_load |=> (load_val == $past(drv_def)) && !load_lock;
	endproperty
	a_drive_from_strap: assert property (p_drive_from_strap)
		else $error("drive reset value not taken from strap");

	property p_size_pins;
		@(posedge ref_clk) disable iff (reset)
		cfg_lo_wr |=> (xfer_size_pin_enable == $past(pwdata[XSIZE_BIT]))
		              && (dma_ack_pin_enable != xfer_size_pin_enable);
	endproperty
	a_size_pins: assert property (p_size_pins)
		else $error("size pin select did not follow write");

	property p_status_pins;
		@(posedge ref_clk) disable iff (reset)
		cfg_lo_wr ##1 !cfg_lo_wr |-> debug_status_pin_enable
		                            == $past(pwdata[DBGPIN_BIT]);
	endproperty
	a_status_pins: assert property (p_status_pins)
		else $error("status pin enable did not follow write");

	property p_watch_enable;
		@(posedge ref_clk) disable iff (reset)
		(cfg_lo_wr && (!watch_lock || debug_mode) && !strap_load)
			|=> bus_watch_enable == $past(pwdata[WATCH_BIT]);
	endproperty
	a_watch_enable: assert property (p_watch_enable)
		else $error("bus watch enable did not follow write");

	property p_timeout;
		@(posedge ref_clk) disable iff (reset)
		(tsel_val == 3'h7) |-> (bus_watch_timeout_sel == 17'h00200)
		                       && (cfg_value[2:0] == 3'h7);
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("shortest bus watch timeout not 512");

	property p_defaults_ro;
		@(posedge ref_clk) disable iff (reset)
		(access_ph && pwrite && hit_defs && !strap_load)
			|=> $stable(defs_value) && $stable(cfg_value);
	endproperty
	a_defaults_ro: assert property (p_defaults_ro)
		else $error("write changed the defaults register");

	property p_cs_map;
		@(posedge ref_clk) disable iff (reset)
		(csmap_def == 2'h1) |-> (cs_pin_select == 3'h4);
	endproperty
	a_cs_map: assert property (p_cs_map)
		else $error("chip select map 01 decoded wrongly");

	property p_mode;
		@(posedge ref_clk) disable iff (reset)
		setup_ph && hit_defs && !pwrite && privileged
			|=> prdata[0] && prdata[31:16] == 16'h0000;
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode bit or upper read bits wrong");

	property p_user_refused;
		@(posedge ref_clk) disable iff (reset)
		(access_ph && !privileged) |-> pslverr
			##1 ($stable(cfg_value) || $past(strap_load));
	endproperty
	a_user_refused: assert property (p_user_refused)
		else $error("user access not refused or had effect");

	property p_load_locked;
		@(posedge ref_clk) disable iff (reset)
		(cfg_hi_wr && load_lock && !debug_mode) |=> $stable(load_val);
	endproperty
	a_load_locked: assert property (p_load_locked)
		else $error("locked drive bit changed");

endmodule // chip_config_regs

// [hdl/reset_strap_capture.sv]
// Reset-time sampling of configuration straps
`timescale 1ns/10ps
module reset_strap_capture
	import cfg_regs_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// Strap pins
	input  wire logic       config_select_pin_n,
	input  wire logic [1:0] cs_map_strap,
	input  wire logic       drive_strap,
	input  wire logic [1:0] boot_strap,
	// Captured defaults
	output logic      [1:0] chip_select_map_default,
	output logic            pad_drive_default,
	output logic      [1:0] boot_port_width,
	output logic            strap_load
);

	strap_state_t state_r;
	strap_state_t state_nxt;
	logic [1:0]   csmap_r;
	logic [1:0]   csmap_nxt;
	logic         drv_r;
	logic         drv_nxt;
	logic [1:0]   boot_r;
	logic [1:0]   boot_nxt;
	logic         sample;
	logic         use_pins;

	// Async reset may only load constants, so pins are read after release
	assign sample    = (state_r == ST_SAMPLE);
	assign use_pins  = sample & ~config_select_pin_n;
	assign csmap_nxt = use_pins ? cs_map_strap : sample ? CSMAP_DEF : csmap_r;
	assign drv_nxt   = use_pins ? drive_strap  : sample ? DRV_DEF   : drv_r;
	assign boot_nxt  = use_pins ? boot_strap   : sample ? BOOT_DEF  : boot_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_SAMPLE: state_nxt = ST_LOAD;
			ST_LOAD:   state_nxt = ST_RUN;
			ST_RUN:    state_nxt = ST_RUN;
			default:   state_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_SAMPLE;
			csmap_r <= CSMAP_DEF;
			drv_r   <= DRV_DEF;
			boot_r  <= BOOT_DEF;
		end else begin
			state_r <= state_nxt;
			csmap_r <= csmap_nxt;
			drv_r   <= drv_nxt;
			boot_r  <= boot_nxt;
		end
	end

	assign chip_select_map_default = csmap_r;
	assign pad_drive_default       = drv_r;
	assign boot_port_width         = boot_r;
	assign strap_load              = (state_r == ST_LOAD);

	property p_defaults_kept;
		@(posedge ref_clk) disable iff (reset)
		(sample && config_select_pin_n) |=>
			(csmap_r == CSMAP_DEF && drv_r == DRV_DEF && boot_r == BOOT_DEF);
	endproperty
	a_defaults_kept: assert property (p_defaults_kept)
		else $error("defaults replaced without select pin");

	property p_defaults_frozen;
		@(posedge ref_clk) disable iff (reset)
		(state_r == ST_RUN) |=> ($stable(csmap_r) && $stable(drv_r)
		                         && $stable(boot_r));
	endproperty
	a_defaults_frozen: assert property (p_defaults_frozen)
		else $error("defaults changed after reset configuration");

endmodule // reset_strap_capture

// [hdl/write_once_field.sv]
// Write-once register field with its own lock flag
`timescale 1ns/10ps
module write_once_field #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         reset,
	// Reset-time initial value
	input  wire logic         init_load,
	input  wire logic [W-1:0] init_value,
	// Software write
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_value,
	input  wire logic         debug_mode,
	// Field state
	output logic      [W-1:0] value,
	output logic              locked
);

	logic [W-1:0] value_r;
	logic [W-1:0] value_nxt;
	logic         locked_r;
	logic         locked_nxt;
	logic         wr_allowed;

	assign wr_allowed = wr_en & (~locked_r | debug_mode);
	assign value_nxt  = init_load  ? init_value :
	                    wr_allowed ? wr_value   : value_r;
	// Debug writes leave the lock open
	assign locked_nxt = locked_r | (wr_en & ~debug_mode);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			value_r  <= RST;
			locked_r <= 1'b0;
		end else begin
			value_r  <= value_nxt;
			locked_r <= locked_nxt;
		end
	end

	assign value  = value_r;
	assign locked = locked_r;

	property p_lock_hold;
		@(posedge ref_clk) disable iff (reset)
		(locked_r && !debug_mode && !init_load) |=> $stable(value_r);
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("locked field changed outside debug");

	property p_debug_open;
		@(posedge ref_clk) disable iff (reset)
		(!locked_r && debug_mode && wr_en && !init_load)
			|=> (!locked_r && value_r == $past(wr_value));
	endproperty
	a_debug_open: assert property (p_debug_open)
		else $error("debug write did not land or locked field");

	property p_first_lock;
		@(posedge ref_clk) disable iff (reset)
		(!locked_r && !debug_mode && wr_en) |=> locked_r [*2];
	endproperty
	a_first_lock: assert property (p_first_lock)
		else $error("lock not set by first normal write");

endmodule // write_once_field

// [verif/chip_config_regs_tb_top.sv]
// Self-checking testbench of the chip configuration registers
`timescale 1ns/10ps
module chip_config_regs_tb_top;
	import cfg_regs_pkg::*;

	// ************************************************
	// Stimulus and observed signals
	// ************************************************
	localparam logic [31:0] cfg_addr = 32'h0011_0004;
	localparam logic [31:0] def_addr = 32'h0011_0008;
	localparam logic [31:0] rsv_addr = 32'h0011_000C;
	localparam logic [31:0] bad_addr = 32'h0011_0010;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [2:0]  pprot = 3'h1;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        debug_mode = 1'b0;
	logic        config_select_pin_n = 1'b1;
	logic [1:0]  cs_map_strap = 2'h0;
	logic        drive_strap = 1'b0;
	logic [1:0]  boot_strap = 2'h0;
	logic        pad_drive_full, xfer_size_pin_enable, dma_ack_pin_enable;
	logic        debug_status_pin_enable, chip_master_mode, bus_watch_enable;
	logic        boot_port_8bit, boot_port_16bit, boot_port_32bit;
	logic [2:0]  cs_pin_select;
	logic [16:0] bus_watch_timeout_sel;
	int          err_total = 0;
	int          n_tests = 0;

	always #5 ref_clk = ~ref_clk;

	chip_config_regs uut (
		.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.debug_mode(debug_mode), .config_select_pin_n(config_select_pin_n),
		.cs_map_strap(cs_map_strap), .drive_strap(drive_strap),
		.boot_strap(boot_strap), .pad_drive_full(pad_drive_full),
		.xfer_size_pin_enable(xfer_size_pin_enable),
		.dma_ack_pin_enable(dma_ack_pin_enable),
		.debug_status_pin_enable(debug_status_pin_enable),
		.cs_pin_select(cs_pin_select), .boot_port_8bit(boot_port_8bit),
		.boot_port_16bit(boot_port_16bit), .boot_port_32bit(boot_port_32bit),
		.chip_master_mode(chip_master_mode),
		.bus_watch_enable(bus_watch_enable),
		.bus_watch_timeout_sel(bus_watch_timeout_sel)
	);

	// ************************************************
	// Shared tasks
	// ************************************************
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
			input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Request held until pready is seen high at a rising edge
	task automatic xfer(input string nm, input logic wr, input logic [31:0] a,
			input logic [31:0] d, input logic [3:0] s, input logic p,
			input logic [31:0] exp_rd, input logic exp_er);
		logic [31:0] rd;
		logic er;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		pprot <= {2'b00, p};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk({nm, " error"}, {31'h0, er}, {31'h0, exp_er});
		if (!wr) chk(nm, rd, exp_rd);
	endtask

	// Sampled mid-cycle so the last write edge has landed
	task automatic outs(input logic [4:0] f, input logic [16:0] tmo);
		@(negedge ref_clk);
		chk("pin controls", {27'h0, pad_drive_full, xfer_size_pin_enable,
			dma_ack_pin_enable, debug_status_pin_enable, bus_watch_enable},
			{27'h0, f});
		chk("timeout", {15'h0, bus_watch_timeout_sel}, {15'h0, tmo});
	endtask

	task automatic do_reset(input logic sel_n, input logic [1:0] v);
		@(posedge ref_clk);
		reset <= 1'b1;
		config_select_pin_n <= sel_n;
		cs_map_strap <= v;
		boot_strap <= v;
		drive_strap <= v[0];
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (3) @(posedge ref_clk);
		// Straps move after capture; defaults must not follow
		cs_map_strap <= ~v;
		boot_strap <= ~v;
		drive_strap <= ~v[0];
		config_select_pin_n <= 1'b0;
	endtask

	// ************************************************
	// Scenarios
	// ************************************************
	task automatic t_reset;
		outs(5'b01001, 17'h10000);
		xfer("cfg reset", 1'b0, cfg_addr, 0, 4'h3, 1'b1, 32'h48, 1'b0);
		xfer("def reset", 1'b0, def_addr, 0, 4'h3, 1'b1, 32'h1, 1'b0);
		chk("master", {31'h0, chip_master_mode}, 32'h1);
	endtask

	task automatic t_access;
		// Zero in every reserved bit, as software must
		xfer("def wr", 1'b1, def_addr, 32'h338, 4'h3, 1'b1, 0, 1'b0);
		xfer("def ro", 1'b0, def_addr, 0, 4'h3, 1'b1, 32'h1, 1'b0);
		xfer("rsv wr", 1'b1, rsv_addr, 0, 4'hF, 1'b1, 0, 1'b0);
		xfer("rsv rd", 1'b0, rsv_addr, 0, 4'hF, 1'b1, 0, 1'b0);
		xfer("unmapped", 1'b0, bad_addr, 0, 4'hF, 1'b1, 0, 1'b1);
		xfer("user wr", 1'b1, cfg_addr, 32'h8000, 4'h2, 1'b0, 0, 1'b1);
		xfer("user rd", 1'b0, cfg_addr, 0, 4'h3, 1'b0, 0, 1'b1);
		xfer("after user", 1'b0, cfg_addr, 0, 4'h3, 1'b1, 32'h48, 1'b0);
	endtask

	task automatic t_drive;
		xfer("drv wr", 1'b1, cfg_addr, 32'h8000, 4'h2, 1'b1, 0, 1'b0);
		outs(5'b11001, 17'h10000);
		xfer("drv wr2", 1'b1, cfg_addr, 0, 4'h2, 1'b1, 0, 1'b0);
		xfer("drv lock", 1'b0, cfg_addr, 0, 4'h3, 1'b1, 32'h8048, 1'b0);
	endtask

	task automatic t_watch;
		debug_mode <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			xfer("dbg wr", 1'b1, cfg_addr, 32'h48 | k, 4'h1, 1'b1, 0, 1'b0);
			outs(5'b11001, 17'h10000 >> k);
		end
		debug_mode <= 1'b0;
		xfer("wr a", 1'b1, cfg_addr, 32'h27, 4'h1, 1'b1, 0, 1'b0);
		outs(5'b10110, 17'h00200);
		xfer("wr b", 1'b1, cfg_addr, 32'h48, 4'h1, 1'b1, 0, 1'b0);
		outs(5'b11000, 17'h00200);
		xfer("cfg lock", 1'b0, cfg_addr, 0, 4'h3, 1'b1, 32'h8047, 1'b0);
	endtask

	task automatic t_strap;
		logic [2:0] cst [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
		logic [2:0] bst [4] = '{3'b001, 3'b010, 3'b100, 3'b001};
		logic [31:0] e;
		for (int i = 0; i < 4; i++) begin
			do_reset(1'b0, i[1:0]);
			e = (i << 8) | (i[0] << 5) | (i << 3) | 1;
			xfer("def strap", 1'b0, def_addr, 0, 4'h3, 1'b1, e, 1'b0);
			chk("cs map", {29'h0, cs_pin_select}, {29'h0, cst[i]});
			chk("boot", {29'h0, boot_port_8bit, boot_port_16bit,
				boot_port_32bit}, {29'h0, bst[i]});
			outs({i[0], 4'b1001}, 17'h10000);
		end
		do_reset(1'b1, 2'h3);
		xfer("def plain", 1'b0, def_addr, 0, 4'h3, 1'b1, 32'h1, 1'b0);
		chk("cs plain", {29'h0, cs_pin_select}, 32'h0);
		outs(5'b01001, 17'h10000);
	endtask

	// ************************************************
	// Main sequence and watchdog
	// ************************************************
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_access();
		t_drive();
		t_watch();
		t_strap();
		final_report();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		final_report();
	end

endmodule // chip_config_regs_tb_top
